/* File: gpi_image.sv */
// Operation
// - direct logic output region defaults to four bytes of data set 1.
// - direct region length is configurable up to all 50 bytes.
// - data set 1 may optionally carry four bytes of collective state.
// - data sets 3 and 4 have a fixed layout, configuration cannot alter it.
// - collective state is two-byte input and output summaries, 1 meaning ok.
// - summary bit 0 controller, 1..12 modules, 13/14 gateways, 15 reserved.
// - one pre-evaluated input byte per expansion module in data set 1.
// - rejected inputs from cross or two-channel checks are forced low.
// - paired inputs: even bit element state, odd bit pair ok flag.
// - one output byte per module holding logic commands.
// - reported command may differ from terminal after overload shut-off.
// - paired outputs: even bit carries command, odd bit held low.
// - data set 1 bytes 32 to 35 hold outputs of modules 9 to 12.
// - two gateways forward received network data to each other.
// - ten controller state bytes sent in the fixed state data set.
// - each module sends four state bytes, little-endian 32-bit word.
// - controller state bits 1 for ok, reserved bits always read 1.
// - at the default length, bytes 0-3 controller io, bytes 4-7 direct logic output data.
`timescale 1ns/10ps
module gpi_image #(
    parameter int NUM_MOD = gpi_pkg::NUM_MOD
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cycle_done,
    input wire logic [31:0] ctrl_io,
    input wire logic [79:0] ctrl_state,
    input wire logic [49:0][7:0] direct_data,
    input wire gpi_pkg::gpi_mod_t [NUM_MOD-1:0] mods,
    input wire logic [14:0] sum_in_ok,
    input wire logic [14:0] sum_out_ok,
    input wire gpi_pkg::gpi_fwd_t gw1_rx,
    input wire gpi_pkg::gpi_fwd_t gw2_rx,
    output gpi_pkg::gpi_fwd_t gw1_tx,
    output gpi_pkg::gpi_fwd_t gw2_tx,
    output logic [15:0] cycle_count
);
    // ********************************************************
    // storage
    // ********************************************************
    logic [7:0] ds1 [gpi_pkg::DS1_LEN];
    logic [7:0] ds3 [gpi_pkg::DS3_LEN];
    logic [7:0] next_ds1 [gpi_pkg::DS1_LEN];
    logic [7:0] next_ds3 [gpi_pkg::DS3_LEN];
    logic [5:0] direct_len;
    logic sum_en;
    logic [5:0] direct_start;
    logic [6:0] direct_end;
    logic [15:0] in_sum;
    logic [15:0] out_sum;
    logic apb_write;
    logic apb_access;
    logic [NUM_MOD-1:0][7:0] mod_in;
    logic [NUM_MOD-1:0][7:0] mod_out;

    // ********************************************************
    // byte builders
    // ********************************************************
    function automatic logic [7:0] in_byte(input gpi_pkg::gpi_mod_t m);
        logic [7:0] v;
        v = m.in_val & ~m.in_reject;
        for (int p = 0; p < 4; p++) begin
            if (m.in_pair_cfg[p]) begin
                v[2*p+1] = m.in_pair_ok[p];
            end
        end
        return v;
    endfunction : in_byte

    function automatic logic [7:0] out_byte(input gpi_pkg::gpi_mod_t m);
        logic [7:0] v;
        // command from logic, not terminal level (overload may cut it)
        v = m.out_cmd;
        for (int p = 0; p < 4; p++) begin
            if (m.out_pair_cfg[p]) begin
                v[2*p+1] = 1'b0;
            end
        end
        return v;
    endfunction : out_byte

    function automatic logic [31:0] pick_word(
        input logic [7:0] img [gpi_pkg::DS3_LEN],
        input int len,
        input logic [7:0] word_idx
    );
        logic [31:0] w;
        int b;
        w = '0;
        for (int k = 0; k < 4; k++) begin
            b = 4 * int'(word_idx) + k;
            if (b < len) begin
                w[8*k +: 8] = img[b];
            end
        end
        return w;
    endfunction : pick_word

    function automatic logic [31:0] ds1_word(input logic [5:0] idx);
        logic [31:0] w;
        int b;
        w = '0;
        for (int k = 0; k < 4; k++) begin
            b = 4 * int'(idx) + k;
            if (b < gpi_pkg::DS1_LEN) begin
                w[8*k +: 8] = ds1[b];
            end
        end
        return w;
    endfunction : ds1_word

    // bit 15 is reserved and held low so it never reads as a good module
    function automatic logic [15:0] sum_word(input logic [14:0] ok);
        logic [15:0] s;
        s = 16'h0000;
        s[0] = ok[0];
        s[12:1] = ok[12:1];
        s[14:13] = ok[14:13];
        return s;
    endfunction : sum_word

    // refusal decode, shared by the error flag and the read data
    function automatic logic ask_refused(
        input logic [11:0] a,
        input logic w,
        input logic [5:0] len
    );
        logic bad;
        bad = 1'b1;
        if (a[1:0] != 2'h0) begin
            bad = 1'b1;
        end else if (a < gpi_pkg::DS3_ADDR) begin
            bad = w || a[7:2] >= gpi_pkg::DS1_WORDS;
        end else if (a < gpi_pkg::DS4_ADDR) begin
            bad = w || a[7:2] >= gpi_pkg::DS3_WORDS;
        end else if (a < gpi_pkg::CTRL_ADDR) begin
            bad = w || a[7:2] >= gpi_pkg::DS4_WORDS;
        end else if (a == gpi_pkg::CTRL_ADDR) begin
            // an oversized region is refused whole, never clipped
            bad = w && len > gpi_pkg::DIRECT_LEN_MAX;
        end else if (a == gpi_pkg::STAT_ADDR) begin
            bad = w;
        end
        return bad;
    endfunction : ask_refused

    function automatic logic [31:0] read_word(input logic [11:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a < gpi_pkg::DS3_ADDR) begin
            w = ds1_word(a[7:2]);
        end else if (a < gpi_pkg::DS4_ADDR) begin
            w = pick_word(ds3, gpi_pkg::DS3_LEN, {2'h0, a[7:2]});
        end else if (a == gpi_pkg::CTRL_ADDR) begin
            w[gpi_pkg::CTRL_LEN_LSB +: 6] = direct_len;
            w[gpi_pkg::CTRL_SUM_BIT] = sum_en;
        end else if (a == gpi_pkg::STAT_ADDR) begin
            w[15:0] = cycle_count;
        end
        return w;
    endfunction : read_word

    // ********************************************************
    // per module bytes
    // ********************************************************
    for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
        assign mod_in[g] = in_byte(mods[g]);
        assign mod_out[g] = out_byte(mods[g]);
    end

    // ********************************************************
    // next images
    // ********************************************************
    always_comb begin
        in_sum = sum_word(sum_in_ok);
        out_sum = sum_word(sum_out_ok);
        // a wide region that cannot fit after the controller bytes
        // slides down so the full image can be used
        if (direct_len > 6'(gpi_pkg::DS1_LEN - gpi_pkg::DS1_DIRECT_BASE))
            begin
            direct_start = 6'(gpi_pkg::DS1_LEN) - direct_len;
        end else begin
            direct_start = 6'(gpi_pkg::DS1_DIRECT_BASE);
        end
        direct_end = {1'b0, direct_start} + {1'b0, direct_len};
    end

    always_comb begin
        for (int i = 0; i < gpi_pkg::DS1_LEN; i++) begin
            next_ds1[i] = 8'h00;
        end
        for (int i = 0; i < gpi_pkg::CTRL_IO_BYTES; i++) begin
            next_ds1[i] = ctrl_io[8*i +: 8];
        end
        for (int m = 0; m < NUM_MOD; m++) begin
            next_ds1[gpi_pkg::DS1_IN_BASE + m] = mod_in[m];
            next_ds1[gpi_pkg::DS1_OUT_BASE + m] = mod_out[m];
        end
        if (sum_en) begin
            next_ds1[gpi_pkg::DS1_SUM_BASE] = in_sum[7:0];
            next_ds1[gpi_pkg::DS1_SUM_BASE + 1] = in_sum[15:8];
            next_ds1[gpi_pkg::DS1_SUM_BASE + 2] = out_sum[7:0];
            next_ds1[gpi_pkg::DS1_SUM_BASE + 3] = out_sum[15:8];
        end
        for (int i = 0; i < gpi_pkg::DS1_LEN; i++) begin
            if (i >= int'(direct_start) && i < int'(direct_end)) begin
                next_ds1[i] = direct_data[i - int'(direct_start)];
            end
        end
    end

    // fixed layout, no configuration input reaches this image
    always_comb begin
        for (int i = 0; i < gpi_pkg::DS3_LEN; i++) begin
            next_ds3[i] = gpi_pkg::RSV_BYTE;
        end
        for (int i = 0; i < gpi_pkg::CTRL_STATE_BYTES; i++) begin
            next_ds3[i] = ctrl_state[8*i +: 8]
                | gpi_pkg::CTRL_RSV_MASK[i];
        end
        for (int m = 0; m < NUM_MOD; m++) begin
            for (int k = 0; k < gpi_pkg::MOD_STATE_BYTES; k++) begin
                next_ds3[gpi_pkg::DS3_MOD_BASE + 4*m + k] =
                    mods[m].state[8*k +: 8];
            end
        end
    end

    // ********************************************************
    // image capture
    // ********************************************************
    // whole image moves in one edge so a read never mixes cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < gpi_pkg::DS1_LEN; i++) begin
                ds1[i] <= 8'h00;
            end
        end else if (cycle_done) begin
            ds1 <= next_ds1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < gpi_pkg::DS3_LEN; i++) begin
                ds3[i] <= gpi_pkg::RSV_BYTE;
            end
        end else if (cycle_done) begin
            ds3 <= next_ds3;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cycle_count <= 16'h0000;
        end else if (cycle_done) begin
            cycle_count <= cycle_count + 16'h0001;
        end
    end

    // ********************************************************
    // gateway to gateway forwarding
    // ********************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gw1_tx <= '0;
            gw2_tx <= '0;
        end else begin
            gw2_tx.valid <= gw1_rx.valid;
            gw1_tx.valid <= gw2_rx.valid;
            if (gw1_rx.valid) begin
                gw2_tx.data <= gw1_rx.data;
            end
            if (gw2_rx.valid) begin
                gw1_tx.data <= gw2_rx.data;
            end
        end
    end

    // ********************************************************
    // apb slave, one wait state
    // ********************************************************
    // access edge that prepares the answer; the write lands one edge later
    assign apb_access = psel && penable && !pready;
    assign apb_write = psel && penable && pready && pwrite;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            direct_len <= gpi_pkg::DIRECT_LEN_RST;
        end else if (apb_write && paddr == gpi_pkg::CTRL_ADDR
            && !pslverr) begin
            direct_len <= pwdata[gpi_pkg::CTRL_LEN_LSB +: 6];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_en <= 1'b0;
        end else if (apb_write && paddr == gpi_pkg::CTRL_ADDR
            && !pslverr) begin
            sum_en <= pwdata[gpi_pkg::CTRL_SUM_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_access;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pslverr <= 1'b0;
        end else if (apb_access) begin
            pslverr <= ask_refused(paddr, pwrite,
                pwdata[gpi_pkg::CTRL_LEN_LSB +: 6]);
        end else begin
            pslverr <= 1'b0;
        end
    end

    // refused accesses answer zero so stale image data never leaks out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (apb_access) begin
            if (ask_refused(paddr, pwrite,
                pwdata[gpi_pkg::CTRL_LEN_LSB +: 6])) begin
                prdata <= 32'h0000_0000;
            end else begin
                prdata <= read_word(paddr);
            end
        end
    end

endmodule : gpi_image

/* File: gpi_pkg.sv */
package gpi_pkg;
    // ********************************************************
    // image geometry
    // ********************************************************
    localparam int DS1_LEN = 50;
    localparam int DS3_LEN = 60;
    localparam int DS4_LEN = 60;
    localparam int NUM_MOD = 12;
    localparam int CTRL_IO_BYTES = 4;
    localparam int CTRL_STATE_BYTES = 10;
    localparam int MOD_STATE_BYTES = 4;
    localparam int DS1_DIRECT_BASE = 4;
    localparam int DS1_DIRECT_SLOTS = 8;
    localparam int DS1_IN_BASE = 12;
    localparam int DS1_OUT_BASE = 24;
    localparam int DS1_SUM_BASE = 36;
    localparam int DS3_MOD_BASE = 12;
    localparam logic [5:0] DIRECT_LEN_RST = 6'h04;
    localparam logic [5:0] DIRECT_LEN_MAX = 6'h32;
    localparam logic [5:0] DS1_WORDS = 6'h0d;
    localparam logic [5:0] DS3_WORDS = 6'h0f;
    localparam logic [5:0] DS4_WORDS = 6'h0f;
    // controller state bytes whose bits are reserved and read as one
    localparam logic [7:0] CTRL_RSV_MASK [CTRL_STATE_BYTES] = '{
        8'h01, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
        8'h00, 8'h00};
    localparam logic [7:0] RSV_BYTE = 8'hff;
    // ********************************************************
    // register map (byte addresses)
    // ********************************************************
    localparam logic [11:0] DS1_ADDR = 12'h000;
    localparam logic [11:0] DS3_ADDR = 12'h100;
    localparam logic [11:0] DS4_ADDR = 12'h200;
    localparam logic [11:0] CTRL_ADDR = 12'h300;
    localparam logic [11:0] STAT_ADDR = 12'h304;
    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_SUM_BIT = 8;
    // ********************************************************
    // carriers
    // ********************************************************
    typedef struct packed {
        logic [7:0] in_val;
        logic [7:0] in_reject;
        logic [3:0] in_pair_ok;
        logic [3:0] in_pair_cfg;
        logic [7:0] out_cmd;
        logic [3:0] out_pair_cfg;
        logic [31:0] state;
    } gpi_mod_t;
    typedef struct packed {
        logic [31:0] data;
        logic valid;
    } gpi_fwd_t;
endpackage : gpi_pkg

/* File: gpi_image_properties.sv */
`timescale 1ns/10ps
module gpi_image_chk #(
    parameter int NUM_MOD = gpi_pkg::NUM_MOD
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cycle_done,
    input wire gpi_pkg::gpi_fwd_t gw1_rx,
    input wire gpi_pkg::gpi_fwd_t gw2_rx,
    input wire gpi_pkg::gpi_fwd_t gw1_tx,
    input wire gpi_pkg::gpi_fwd_t gw2_tx,
    input wire logic [15:0] cycle_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence waiting;
        psel && penable && !pready;
    endsequence
    sequence rd_at(logic [11:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    chk_wait_state: assert property (waiting |=> pready)
        else $error("no answer after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_fwd_to_two: assert property (
        gw1_rx.valid |=> gw2_tx.valid && gw2_tx.data == $past(gw1_rx.data))
        else $error("word not forwarded to second gateway");
    chk_fwd_to_one: assert property (
        gw2_rx.valid |=> gw1_tx.valid && gw1_tx.data == $past(gw2_rx.data))
        else $error("word not forwarded to first gateway");
    chk_fwd_quiet: assert property (!gw1_rx.valid |=> !gw2_tx.valid)
        else $error("forward strobe without a received word");
    chk_count_step: assert property (
        cycle_done |=> cycle_count == $past(cycle_count) + 16'h0001)
        else $error("cycle count did not step");
    chk_count_hold: assert property (
        !cycle_done |=> $stable(cycle_count))
        else $error("cycle count moved without a cycle end");
    chk_rsv_ones: assert property (
        rd_at(12'h108) |-> prdata[31:16] == 16'hffff)
        else $error("reserved state bytes not all ones");
    chk_ds4_zero: assert property (
        pready && !pwrite && paddr[11:8] == 4'h2 |-> prdata == 32'h0)
        else $error("fixed data set 4 not zero");
    chk_img_wr_err: assert property (
        pready && pwrite && paddr < 12'h300 |-> pslverr)
        else $error("image write not refused");
    chk_fwd_quiet_one: assert property (
        !gw2_rx.valid |=> !gw1_tx.valid)
        else $error("forward strobe without a received word");
    chk_err_in_answer: assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
endmodule : gpi_image_chk
bind gpi_image gpi_image_chk #(.NUM_MOD(NUM_MOD)) u_chk (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cycle_done(cycle_done), .gw1_rx(gw1_rx), .gw2_rx(gw2_rx),
    .gw1_tx(gw1_tx), .gw2_tx(gw2_tx), .cycle_count(cycle_count));

/* File: gpi_net_master.sv */
`timescale 1ns/10ps
module gpi_net_master (
    input wire logic clk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [11:0] paddr = 12'h000,
    output logic [31:0] pwdata = 32'h0
);
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines change so a stale value cannot pass
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : gpi_net_master

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, cycle_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ctrl_io;
    logic [79:0] ctrl_state;
    logic [49:0][7:0] direct_data;
    gpi_pkg::gpi_mod_t [11:0] mods;
    logic [14:0] sum_in_ok, sum_out_ok;
    gpi_pkg::gpi_fwd_t gw1_rx, gw2_rx, gw1_tx, gw2_tx;
    logic [15:0] cycle_count;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    gpi_net_master nm (.clk, .prdata, .pready, .pslverr, .psel, .penable,
        .pwrite, .paddr, .pwdata);
    gpi_image #(.NUM_MOD(12)) dut (.clk, .rst_b, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .cycle_done, .ctrl_io,
        .ctrl_state, .direct_data, .mods, .sum_in_ok, .sum_out_ok, .gw1_rx,
        .gw2_rx, .gw1_tx, .gw2_tx, .cycle_count);
    task automatic chk32(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : chk32
    task automatic chk1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %b got %b", what, exp, got);
        end
    endtask : chk1
    // reads compare data too; refused reads must return zero
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        nm.xfer(w, a, d, q, e);
        chk1($sformatf("error flag %h", a), err, e);
        if (!w) chk32($sformatf("word %h", a), exp, q);
    endtask : acc
    task automatic latch();
        @(posedge clk);
        cycle_done <= 1'b1;
        @(posedge clk);
        cycle_done <= 1'b0;
    endtask : latch
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        cycle_done = 1'b0;
        ctrl_io = 32'h44332211;
        ctrl_state = 80'h0;
        sum_in_ok = 15'h2005;
        sum_out_ok = 15'h4003;
        gw1_rx = '0;
        gw2_rx = '0;
        for (int i = 0; i < 50; i++) direct_data[i] = 8'ha0 + 8'(i);
        for (int m = 0; m < 12; m++) mods[m] = '{8'hff, 8'h00, 4'h0, 4'h0,
            8'h10 + 8'(m), 4'h0, 32'h01020300 + 32'(m)};
        mods[0].in_reject = 8'h0f;
        mods[1].in_pair_cfg = 4'h1;
        mods[2].in_pair_cfg = 4'h2;
        mods[2].in_pair_ok = 4'h2;
        mods[9].out_cmd = 8'hff;
        mods[9].out_pair_cfg = 4'h1;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        latch();
        acc(1'b0, 12'h000, 32'h0, 32'h44332211, 1'b0);
        acc(1'b0, 12'h004, 32'h0, 32'ha3a2a1a0, 1'b0);
        acc(1'b0, 12'h00c, 32'h0, 32'hfffffdf0, 1'b0);
        acc(1'b0, 12'h020, 32'h0, 32'h1b1afd18, 1'b0);
        acc(1'b0, 12'h024, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h100, 32'h0, 32'h00003001, 1'b0);
        acc(1'b0, 12'h104, 32'h0, 32'hff000000, 1'b0);
        acc(1'b0, 12'h108, 32'h0, 32'hffff0000, 1'b0);
        acc(1'b0, 12'h10c, 32'h0, 32'h01020300, 1'b0);
        acc(1'b0, 12'h138, 32'h0, 32'h0102030b, 1'b0);
        acc(1'b0, 12'h200, 32'h0, 32'h0, 1'b0);
        $display("test layout done");
        @(posedge clk);
        ctrl_io <= 32'h55667788;
        acc(1'b0, 12'h000, 32'h0, 32'h44332211, 1'b0);
        latch();
        acc(1'b0, 12'h000, 32'h0, 32'h55667788, 1'b0);
        $display("test capture done");
        acc(1'b1, 12'h300, 32'h104, 32'h0, 1'b0);
        latch();
        acc(1'b0, 12'h024, 32'h0, 32'h40032005, 1'b0);
        acc(1'b0, 12'h300, 32'h0, 32'h00000104, 1'b0);
        $display("test summary done");
        acc(1'b1, 12'h300, 32'h32, 32'h0, 1'b0);
        acc(1'b1, 12'h300, 32'h33, 32'h0, 1'b1);
        acc(1'b0, 12'h300, 32'h0, 32'h00000032, 1'b0);
        latch();
        acc(1'b0, 12'h000, 32'h0, 32'ha3a2a1a0, 1'b0);
        acc(1'b0, 12'h030, 32'h0, 32'h0000d1d0, 1'b0);
        $display("test direct done");
        acc(1'b1, 12'h000, 32'h1, 32'h0, 1'b1);
        acc(1'b1, 12'h100, 32'h1, 32'h0, 1'b1);
        acc(1'b0, 12'h002, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 12'h400, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 12'h304, 32'h0, 32'h00000004, 1'b0);
        $display("test refusals done");
        @(posedge clk);
        gw1_rx <= '{32'hcafe0001, 1'b1};
        @(posedge clk);
        gw1_rx.valid <= 1'b0;
        gw2_rx <= '{32'h0bad0002, 1'b1};
        #1 chk32("second gateway tx", 32'hcafe0001, gw2_tx.data);
        chk1("second gateway strobe", 1'b1, gw2_tx.valid);
        @(posedge clk);
        gw2_rx.valid <= 1'b0;
        #1 chk32("first gateway tx", 32'h0bad0002, gw1_tx.data);
        chk1("first gateway strobe", 1'b1, gw1_tx.valid);
        chk1("second strobe drop", 1'b0, gw2_tx.valid);
        $display("test forward done");
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        acc(1'b0, 12'h300, 32'h0, 32'h00000004, 1'b0);
        acc(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h100, 32'h0, 32'hffffffff, 1'b0);
        acc(1'b0, 12'h304, 32'h0, 32'h0, 1'b0);
        chk32("first gateway tx", 32'h0, gw1_tx.data);
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb
